/* pchp_regs.svh */
`ifndef PCHP_REGS_SVH
`define PCHP_REGS_SVH

// ----------------------------------------------------------------
// Constants
// ----------------------------------------------------------------
`define PCHP_TARGET_ADDR 7'h20
`define PCHP_MSG_LAST    4'hE
`define PCHP_CLK_HZ      32'h0EE6B280
`define PCHP_LINK_HZ     32'h000F4240
`define PCHP_LINK_HALF   (`PCHP_CLK_HZ / (32'h00000002 * `PCHP_LINK_HZ))
`define PCHP_SELF_RST_US 32'h00000064
`define PCHP_SELF_RST_CYC ((`PCHP_CLK_HZ / 32'h000F4240) * `PCHP_SELF_RST_US)
`define PCHP_LED_BITS    16
`define PCHP_LED_LAST    4'hF

`endif

/* pchp_pkg.sv */
package pchp_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACKA, ST_WRITE, ST_WHOLD, ST_ACKW, ST_LOAD, ST_READ, ST_RACK
  } pchp_i2c_st_t;

  typedef enum logic [1:0] {
    L_IDLE, L_SHIFT, L_LATCH
  } pchp_led_st_t;

  typedef logic [8:0] pchp_word_t;

endpackage : pchp_pkg

/* pchp_if.sv */
`timescale 1ns/10ps

interface pchp_if;
  import pchp_pkg::*;

  logic       in_valid;
  logic       in_ready;
  pchp_word_t in_data;
  logic       out_valid;
  logic       out_ready;
  pchp_word_t out_data;

  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : pchp_if

/* pchp_buf.sv */
`timescale 1ns/10ps

module pchp_buf
  import pchp_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  pchp_if.fifo     b
);

  pchp_word_t mem [2];
  logic [1:0] cnt;
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] next_cnt;
  logic       next_wr_ptr;
  logic       next_rd_ptr;
  logic       push;
  logic       pop;

  // ----------------------------------------------------------------
  // Two-entry queue
  // ----------------------------------------------------------------
  assign b.in_ready  = (cnt != 2'h2);
  assign b.out_valid = (cnt != 2'h0);
  assign b.out_data  = mem[rd_ptr];
  assign push        = b.in_valid && b.in_ready;
  assign pop         = b.out_valid && b.out_ready;

  always_comb begin
    next_wr_ptr = push ? ~wr_ptr : wr_ptr;
    next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
    next_cnt    = cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt    <= 2'h0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_entry
    always_ff @(posedge CLK) begin
      if (push && (wr_ptr == 1'(i))) begin
        mem[i] <= b.in_data;
      end
    end
  end

  a_no_overflow: assert property (@(posedge CLK) disable iff (RST)
                                  cnt == 2'h2 && !b.out_ready |=> cnt == 2'h2 && b.out_data == $past(b.out_data))
    else $error("buffer lost a word while full");

endmodule : pchp_buf

/* pchp_top.sv */
// Functional notes
// RULE1: Commands and replies on the serial data line travel as fixed fifteen-byte messages.
// RULE2: The host runs the serial clock at 400 kHz or less and waits while the clock is held low.
// RULE3: While the block cannot yet serve a transfer it holds the serial clock low.
// RULE4: The reply-pending output goes low once a reply message is available.
// RULE5: The host polls the reply-pending line and reads only once a message is ready.
// RULE6: After the host has read the reply, the reply-pending output returns high.
// RULE7: The interrupt output stays low while any event selected by the host is in progress.
// RULE8: A self-reset drives the two-way reset pin low for about 100 us.
// RULE9: A low level on the reset pin from the host keeps the controller in reset.
// RULE10: The LED output enable is active low and enables the LED outputs when low.
// RULE11: The LED select output is low while LED data is shifted.
// RULE12: The LED strobe output pulses low to latch the shifted LED data.
// RULE13: The fan output is high while temperature exceeds the alarm threshold, low otherwise.
// RULE14: The LED stream is clocked by the 1 MHz manager link clock.
// RULE15: The serial target answers only its own address and ignores others.
`timescale 1ns/10ps
`include "pchp_regs.svh"

module pchp_top
  import pchp_pkg::*;
#(
  parameter int unsigned SELF_RST_CYC = `PCHP_SELF_RST_CYC
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       HOST_SERIAL_CLOCK_I,
  output logic            HOST_SERIAL_CLOCK_OE_N,
  input  wire logic       HOST_SERIAL_DATA_I,
  output logic            HOST_SERIAL_DATA_OE_N,
  output logic            CMD_VALID,
  input  wire logic       CMD_READY,
  output logic [7:0]      CMD_DATA,
  output logic            CMD_LAST,
  input  wire logic       REPLY_LOAD,
  input  wire logic       REPLY_VALID,
  output logic            REPLY_READY,
  input  wire logic [7:0] REPLY_DATA,
  output logic            REPLY_PENDING_N,
  input  wire logic [7:0] EVENT_ACTIVE,
  input  wire logic [7:0] EVENT_MASK,
  output logic            EVENT_IRQ_N,
  input  wire logic       HOST_RESET_N_I,
  output logic            HOST_RESET_N_OE_N,
  input  wire logic       SELF_RESET_REQ,
  output logic            CORE_RESET_N,
  input  wire logic       LED_START,
  input  wire logic [15:0] LED_DATA,
  input  wire logic       LED_ENABLE,
  output logic            LED_BUSY,
  output logic            LED_SERIAL_DATA,
  output logic            LED_SELECT_N,
  output logic            LED_STROBE_N,
  output logic            LED_OUTPUT_ENABLE_N,
  output logic            MANAGER_LINK_CLOCK,
  input  wire logic [7:0] TEMP,
  input  wire logic [7:0] TEMP_ALARM,
  output logic            FAN_CONTROL
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] scl_sy, sda_sy, rst_sy;
  logic       scl_q, sda_q;
  always_ff @(posedge CLK) begin
    if (RST) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      rst_sy <= 2'h3;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
    end else begin
      scl_sy <= {scl_sy[0], HOST_SERIAL_CLOCK_I};
      sda_sy <= {sda_sy[0], HOST_SERIAL_DATA_I};
      rst_sy <= {rst_sy[0], HOST_RESET_N_I};
      scl_q  <= scl_sy[1];
      sda_q  <= sda_sy[1];
    end
  end
  logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
  assign scl      = scl_sy[1];
  assign sda      = sda_sy[1];
  assign scl_rise = scl && !scl_q;
  assign scl_fall = !scl && scl_q;
  assign start_c  = scl && scl_q && sda_q && !sda;
  assign stop_c   = scl && scl_q && !sda_q && sda;

  // ----------------------------------------------------------------
  // Reset pin
  // ----------------------------------------------------------------
  int unsigned rst_cnt, next_rst_cnt;
  logic        rst_drive, next_rst_drive, core_hold, local_rst;
  assign core_hold = !rst_sy[1] && !rst_drive;
  assign local_rst = RST || core_hold;                                      // RULE9
  always_comb begin
    next_rst_cnt   = rst_cnt;
    next_rst_drive = rst_drive;
    if (!rst_drive && SELF_RESET_REQ) begin
      next_rst_drive = 1'b1;                                                 // RULE8
      next_rst_cnt   = 1;
    end else if (rst_drive) begin
      if (rst_cnt >= SELF_RST_CYC) begin
        next_rst_drive = 1'b0;
      end else begin
        next_rst_cnt = rst_cnt + 1;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      rst_cnt           <= 0;
      rst_drive         <= 1'b0;
      HOST_RESET_N_OE_N <= 1'b1;
      CORE_RESET_N      <= 1'b1;
    end else begin
      rst_cnt           <= next_rst_cnt;
      rst_drive         <= next_rst_drive;
      HOST_RESET_N_OE_N <= !next_rst_drive;                                  // RULE8
      CORE_RESET_N      <= !core_hold;                                       // RULE9
    end
  end

  // ----------------------------------------------------------------
  // Serial target
  // ----------------------------------------------------------------
  pchp_if bq ();
  pchp_buf u_buf (.CLK(CLK), .RST(local_rst), .b(bq.fifo));
  assign CMD_VALID    = bq.out_valid;
  assign CMD_DATA     = bq.out_data[7:0];
  assign CMD_LAST     = bq.out_data[8];
  assign bq.out_ready = CMD_READY;

  pchp_i2c_st_t st, next_st;
  logic [3:0] bit_cnt, next_bit_cnt, wr_cnt, next_wr_cnt, rd_cnt, next_rd_cnt;
  logic [7:0] shreg, next_shreg;
  logic       rw, next_rw, pending, next_pending, take, push;
  logic       next_sda_oe_n, next_scl_oe_n;
  assign take        = (st == ST_LOAD) && REPLY_VALID;
  assign REPLY_READY = take;
  assign push        = (st == ST_WHOLD) && bq.in_ready;
  assign bq.in_valid = push;
  assign bq.in_data  = {wr_cnt == `PCHP_MSG_LAST, shreg};                  // RULE1

  always_comb begin
    next_st       = st;
    next_bit_cnt  = bit_cnt;
    next_shreg    = shreg;
    next_rw       = rw;
    next_wr_cnt   = wr_cnt;
    next_rd_cnt   = rd_cnt;
    next_sda_oe_n = HOST_SERIAL_DATA_OE_N;
    next_scl_oe_n = 1'b1;
    next_pending  = pending;
    if (take && rd_cnt == `PCHP_MSG_LAST) begin
      next_pending = 1'b0;                                                   // RULE6
    end
    if (take) begin
      next_rd_cnt = (rd_cnt == `PCHP_MSG_LAST) ? 4'h0 : rd_cnt + 4'h1;      // RULE1
    end
    if (REPLY_LOAD) begin
      next_pending = 1'b1;                                                   // RULE4
      next_rd_cnt  = 4'h0;
    end
    if (start_c) begin
      next_st       = ST_ADDR;
      next_bit_cnt  = 4'h0;
      next_wr_cnt   = 4'h0;
      next_sda_oe_n = 1'b1;
    end else if (stop_c) begin
      next_st       = ST_IDLE;
      next_sda_oe_n = 1'b1;
    end else begin
      unique case (st)
        ST_IDLE: begin
        end
        ST_ADDR, ST_WRITE: begin
          if (scl_rise && bit_cnt != 4'h8) begin
            next_shreg   = {shreg[6:0], sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            if (st == ST_WRITE) begin
              next_st = ST_WHOLD;
            end else if (shreg[7:1] == `PCHP_TARGET_ADDR) begin
              next_st       = ST_ACKA;
              next_rw       = shreg[0];
              next_sda_oe_n = 1'b0;
            end else begin
              next_st = ST_IDLE;                                             // RULE15
            end
          end
        end
        ST_WHOLD: begin
          if (push) begin
            next_st       = ST_ACKW;
            next_sda_oe_n = 1'b0;
            next_wr_cnt   = (wr_cnt == `PCHP_MSG_LAST) ? 4'h0 : wr_cnt + 4'h1;
          end else begin
            next_scl_oe_n = 1'b0;                                            // RULE3
          end
        end
        ST_ACKA, ST_ACKW: begin
          if (scl_fall) begin
            next_sda_oe_n = 1'b1;
            next_bit_cnt  = 4'h0;
            next_st       = (st == ST_ACKA && rw) ? ST_LOAD : ST_WRITE;
            next_scl_oe_n = !(st == ST_ACKA && rw && !REPLY_VALID);
          end
        end
        ST_LOAD: begin
          if (take) begin
            next_st       = ST_READ;
            next_shreg    = REPLY_DATA;
            next_bit_cnt  = 4'h0;
            next_sda_oe_n = REPLY_DATA[7];
          end else begin
            next_scl_oe_n = 1'b0;                                            // RULE3
          end
        end
        ST_READ: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h7) begin
              next_st       = ST_RACK;
              next_sda_oe_n = 1'b1;
            end else begin
              next_shreg    = {shreg[6:0], 1'b0};
              next_bit_cnt  = bit_cnt + 4'h1;
              next_sda_oe_n = shreg[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise && sda) begin
            next_st = ST_IDLE;
          end else if (scl_fall) begin
            next_st       = ST_LOAD;
            next_scl_oe_n = !(!REPLY_VALID);
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (local_rst) begin
      st                     <= ST_IDLE;
      bit_cnt                <= 4'h0;
      shreg                  <= 8'h00;
      rw                     <= 1'b0;
      wr_cnt                 <= 4'h0;
      rd_cnt                 <= 4'h0;
      pending                <= 1'b0;
      HOST_SERIAL_DATA_OE_N  <= 1'b1;
      HOST_SERIAL_CLOCK_OE_N <= 1'b1;
    end else begin
      st                     <= next_st;
      bit_cnt                <= next_bit_cnt;
      shreg                  <= next_shreg;
      rw                     <= next_rw;
      wr_cnt                 <= next_wr_cnt;
      rd_cnt                 <= next_rd_cnt;
      pending                <= next_pending;
      HOST_SERIAL_DATA_OE_N  <= next_sda_oe_n;
      HOST_SERIAL_CLOCK_OE_N <= next_scl_oe_n;
    end
  end
  assign REPLY_PENDING_N = !pending;                                         // RULE4

  // ----------------------------------------------------------------
  // Interrupt and fan
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (local_rst) begin
      EVENT_IRQ_N <= 1'b1;
      FAN_CONTROL <= 1'b0;
    end else begin
      EVENT_IRQ_N <= !(|(EVENT_ACTIVE & EVENT_MASK));                        // RULE7
      FAN_CONTROL <= TEMP > TEMP_ALARM;                                      // RULE13
    end
  end

  // ----------------------------------------------------------------
  // Link clock and LED stream
  // ----------------------------------------------------------------
  logic [6:0]   div, next_div;
  logic         next_link, fall_en;
  pchp_led_st_t lst, next_lst;
  logic [15:0]  lsr, next_lsr;
  logic [3:0]   lcnt, next_lcnt;
  logic         next_sdo, next_sel_n, next_stb_n;
  assign fall_en  = MANAGER_LINK_CLOCK && (div == 7'(`PCHP_LINK_HALF - 1));
  assign LED_BUSY = (lst != L_IDLE);

  always_comb begin
    next_div   = (div == 7'(`PCHP_LINK_HALF - 1)) ? 7'h00 : div + 7'h01;    // RULE14
    next_link  = (div == 7'(`PCHP_LINK_HALF - 1)) ? !MANAGER_LINK_CLOCK : MANAGER_LINK_CLOCK;
    next_lst   = lst;
    next_lsr   = lsr;
    next_lcnt  = lcnt;
    next_sdo   = LED_SERIAL_DATA;
    next_sel_n = LED_SELECT_N;
    next_stb_n = LED_STROBE_N;
    unique case (lst)
      L_IDLE: begin
        if (LED_START) begin
          next_lst   = L_SHIFT;
          next_lsr   = LED_DATA;
          next_lcnt  = 4'h0;
          next_sdo   = LED_DATA[15];
          next_sel_n = 1'b0;                                                 // RULE11
        end
      end
      L_SHIFT: begin
        if (fall_en) begin                                                   // RULE14
          if (lcnt == `PCHP_LED_LAST) begin
            next_lst   = L_LATCH;
            next_sel_n = 1'b1;
            next_stb_n = 1'b0;                                               // RULE12
          end else begin
            next_lsr  = {lsr[14:0], 1'b0};
            next_sdo  = lsr[14];
            next_lcnt = lcnt + 4'h1;
          end
        end
      end
      L_LATCH: begin
        if (fall_en) begin
          next_lst   = L_IDLE;
          next_stb_n = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (local_rst) begin
      div                 <= 7'h00;
      MANAGER_LINK_CLOCK  <= 1'b0;
      lst                 <= L_IDLE;
      lsr                 <= 16'h0000;
      lcnt                <= 4'h0;
      LED_SERIAL_DATA     <= 1'b0;
      LED_SELECT_N        <= 1'b1;
      LED_STROBE_N        <= 1'b1;
      LED_OUTPUT_ENABLE_N <= 1'b1;
    end else begin
      div                 <= next_div;
      MANAGER_LINK_CLOCK  <= next_link;
      lst                 <= next_lst;
      lsr                 <= next_lsr;
      lcnt                <= next_lcnt;
      LED_SERIAL_DATA     <= next_sdo;
      LED_SELECT_N        <= next_sel_n;
      LED_STROBE_N        <= next_stb_n;
      LED_OUTPUT_ENABLE_N <= !LED_ENABLE;                                    // RULE10
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (local_rst);

  int unsigned drv_len, hi_len;
  always_ff @(posedge CLK) begin
    drv_len <= rst_drive ? drv_len + 1 : 0;
    hi_len  <= MANAGER_LINK_CLOCK ? hi_len + 1 : 0;
  end

  a_msg_last_flag: assert property (push && bq.in_data[8] |=> wr_cnt == 4'h0) // RULE1
    else $error("message count not restarted after last byte");
  a_stretch_load: assert property (st == ST_LOAD && !REPLY_VALID |=> !HOST_SERIAL_CLOCK_OE_N) // RULE3
    else $error("clock not held while reply missing");
  a_pending_set: assert property (REPLY_LOAD |=> !REPLY_PENDING_N) // RULE4
    else $error("reply pending not raised");
  a_pending_clear: assert property (take && rd_cnt == `PCHP_MSG_LAST && !REPLY_LOAD |=> REPLY_PENDING_N) // RULE6
    else $error("reply pending not released");
  a_irq_event: assert property (|(EVENT_ACTIVE & EVENT_MASK) |=> !EVENT_IRQ_N) // RULE7
    else $error("interrupt not asserted");
  a_self_rst_len: assert property (disable iff (RST) $fell(rst_drive) |-> drv_len == SELF_RST_CYC) // RULE8
    else $error("self reset pulse length wrong");
  a_led_enable: assert property ($rose(LED_ENABLE) |=> !LED_OUTPUT_ENABLE_N) // RULE10
    else $error("LED enable not driven low");
  a_select_shift: assert property (lst == L_SHIFT |-> !LED_SELECT_N && LED_STROBE_N) // RULE11
    else $error("select not low during shift");
  a_strobe_latch: assert property (lst == L_LATCH |-> !LED_STROBE_N && LED_SELECT_N) // RULE12
    else $error("strobe not low in latch");
  a_fan_alarm: assert property (TEMP > TEMP_ALARM |=> FAN_CONTROL) // RULE13
    else $error("fan not on above alarm");
  a_link_half: assert property ($fell(MANAGER_LINK_CLOCK) |-> hi_len == `PCHP_LINK_HALF) // RULE14
    else $error("link clock high time wrong");
  a_addr_ignore: assert property (st == ST_ADDR && scl_fall && bit_cnt == 4'h8 && shreg[7:1] != `PCHP_TARGET_ADDR
                                  && !start_c |=> st == ST_IDLE && HOST_SERIAL_DATA_OE_N) // RULE15
    else $error("foreign address answered");

  c_write_byte: cover property (push);
  c_read_byte: cover property (take);
  c_led_frame: cover property (lst == L_LATCH);
  c_self_reset: cover property ($fell(rst_drive));
  c_reply_stretch: cover property (st == ST_LOAD && !REPLY_VALID);

endmodule : pchp_top

/* pchp_host_model.sv */
`timescale 1ns/10ps

module pchp_host_model (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_rel,
  output logic      sda_rel
);
  // ----------------------------------------
  // Open-drain master, lines idle released
  // ----------------------------------------
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  // One bit, waiting out a stretch of up to 20000 ns
  task automatic bit_io(input logic b, output logic r);
    int n;
    n = 0;
    #15;
    sda_rel = b;
    #46;
    scl_rel = 1'b1;
    #1;
    while (scl !== 1'b1 && n < 5000) begin
      #4;
      n++;
    end
    #63;
    r = sda;
    scl_rel = 1'b0;
  endtask : bit_io

  task automatic start();
    wt(4);
    sda_rel = 1'b1;
    wt(12);
    scl_rel = 1'b1;
    wt(16);
    sda_rel = 1'b0;
    wt(16);
    scl_rel = 1'b0;
  endtask : start

  task automatic stop();
    wt(4);
    sda_rel = 1'b0;
    wt(12);
    scl_rel = 1'b1;
    wt(16);
    sda_rel = 1'b1;
    wt(16);
  endtask : stop

  task automatic byte_io(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ai, ak);
  endtask : byte_io
endmodule : pchp_host_model

/* pchp_top_tb_top.sv */
`timescale 1ns/10ps

module pchp_top_tb_top;
  import pchp_pkg::*;
  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic        CMD_READY, REPLY_LOAD, REPLY_VALID, SELF_RESET_REQ, LED_START, LED_ENABLE;
  logic [7:0]  REPLY_DATA, EVENT_ACTIVE, EVENT_MASK, TEMP, TEMP_ALARM;
  logic [15:0] LED_DATA;
  logic        HOST_SERIAL_CLOCK_OE_N, HOST_SERIAL_DATA_OE_N, CMD_VALID, CMD_LAST, REPLY_READY;
  logic        REPLY_PENDING_N, EVENT_IRQ_N, HOST_RESET_N_OE_N, CORE_RESET_N, LED_BUSY;
  logic        LED_SERIAL_DATA, LED_SELECT_N, LED_STROBE_N, LED_OUTPUT_ENABLE_N;
  logic        MANAGER_LINK_CLOCK, FAN_CONTROL;
  logic [7:0]  CMD_DATA, q;
  logic        scl_rel, sda_rel, ak, k, e;
  logic        rst_rel = 1'b1;
  logic [8:0]  got[$];
  logic [16:0] ev[4] = '{17'h1_0100, 17'h0_8180, 17'h1_02FD, 17'h0_FF01};
  logic [16:0] fn[4] = '{17'h0_5050, 17'h1_5150, 17'h0_4F50, 17'h1_FF00};
  int          fail_count = 0;
  int          checks = 0;
  int          n;
  longint      t0;
  wire         scl = HOST_SERIAL_CLOCK_OE_N & scl_rel;
  wire         sda = HOST_SERIAL_DATA_OE_N & sda_rel;
  wire         rst_pin = HOST_RESET_N_OE_N & rst_rel;

  always #2 CLK = ~CLK;

  pchp_top #(.SELF_RST_CYC(20)) uut (
    .*,
    .HOST_SERIAL_CLOCK_I (scl),
    .HOST_SERIAL_DATA_I  (sda),
    .HOST_RESET_N_I      (rst_pin)
  );

  pchp_host_model host (.clk(CLK), .scl(scl), .sda(sda), .scl_rel(scl_rel), .sda_rel(sda_rel));

  // ----------------------------------------
  // Consumer and reply source
  // ----------------------------------------
  always @(posedge CLK) begin
    if (CMD_VALID === 1'b1 && CMD_READY === 1'b1) got.push_back({CMD_LAST, CMD_DATA});
    if (REPLY_READY === 1'b1) REPLY_DATA <= REPLY_DATA + 8'h01;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic results();
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  task automatic cyc(input int c);
    repeat (c) @(posedge CLK);
    #1;
  endtask : cyc

  task automatic wr(input logic [6:0] a, input int nb, output logic ka);
    host.start();
    host.byte_io({a, 1'b0}, 1'b1, q, ka);
    for (int i = 0; i < nb; i++) begin
      host.byte_io(8'h10 + 8'(i), 1'b1, q, k);
    end
    host.stop();
  endtask : wr

  initial begin
    repeat (60000) @(posedge CLK);
    fail_count++;
    results();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {CMD_READY, REPLY_LOAD, REPLY_VALID, SELF_RESET_REQ, LED_START, LED_ENABLE} = 6'h08;
    {REPLY_DATA, EVENT_ACTIVE, EVENT_MASK, TEMP, TEMP_ALARM} = 40'h40_0000_0000;
    LED_DATA = 16'hA5C3;
    cyc(6);
    RST = 1'b0;
    cyc(4);
    chk("pending idle", REPLY_PENDING_N, 16'h0001);
    wr(7'h21, 2, ak);
    chk("foreign ack", ak, 16'h0001);
    chk("foreign bytes", 16'(got.size()), 16'h0000);
    fork
      wr(7'h20, 15, ak);
      begin
        cyc(2500);
        chk("stretch", HOST_SERIAL_CLOCK_OE_N, 16'h0000);
        CMD_READY = 1'b1;
      end
    join
    cyc(4);
    chk("own ack", ak, 16'h0000);
    chk("msg bytes", 16'(got.size()), 16'h000F);
    for (int i = 0; i < got.size(); i++) begin
      chk("cmd byte", 16'(got[i]), {7'h00, i == 14, 8'h10 + 8'(i)});
    end
    REPLY_LOAD = 1'b1;
    cyc(1);
    REPLY_LOAD = 1'b0;
    cyc(2);
    chk("pending set", REPLY_PENDING_N, 16'h0000);
    REPLY_VALID = 1'b0;
    n = 0;
    while (REPLY_PENDING_N !== 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
    host.start();
    fork
      host.byte_io({7'h20, 1'b1}, 1'b1, q, k);
      begin
        cyc(1000);
        chk("reply stretch", HOST_SERIAL_CLOCK_OE_N, 16'h0000);
        REPLY_VALID = 1'b1;
      end
    join
    for (int i = 0; i < 15; i++) begin
      host.byte_io(8'hFF, i == 14, q, k);
      chk("reply byte", 16'(q), 16'h0040 + 16'(i));
      if (i == 13) chk("pending mid", REPLY_PENDING_N, 16'h0000);
    end
    host.stop();
    cyc(4);
    chk("pending clear", REPLY_PENDING_N, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      {e, EVENT_ACTIVE, EVENT_MASK} = ev[i];
      {k, TEMP, TEMP_ALARM} = fn[i];
      cyc(3);
      chk("irq", EVENT_IRQ_N, 16'(e));
      chk("fan", FAN_CONTROL, 16'(k));
    end
    LED_ENABLE = 1'b1;
    cyc(3);
    chk("led oe", LED_OUTPUT_ENABLE_N, 16'h0000);
    @(negedge MANAGER_LINK_CLOCK);
    #1;
    LED_START = 1'b1;
    cyc(1);
    LED_START = 1'b0;
    chk("led busy", LED_BUSY, 16'h0001);
    for (int i = 0; i < 16; i++) begin
      @(posedge MANAGER_LINK_CLOCK);
      #1;
      if (i == 0) t0 = $time;
      chk("led select", LED_SELECT_N, 16'h0000);
      chk("led bit", LED_SERIAL_DATA, 16'(LED_DATA[15-i]));
    end
    chk("link period", 16'(($time - t0) / 15), 16'h03E8);
    n = 0;
    while (LED_STROBE_N !== 1'b0 && n < 1000) begin
      cyc(1);
      n++;
    end
    chk("strobe select", LED_SELECT_N, 16'h0001);
    n = 0;
    while (LED_STROBE_N === 1'b0 && n < 1000) begin
      cyc(1);
      n++;
    end
    chk("strobe width", 16'(n), 16'h00FA);
    chk("led idle", LED_BUSY, 16'h0000);
    SELF_RESET_REQ = 1'b1;
    cyc(1);
    SELF_RESET_REQ = 1'b0;
    n = 0;
    while (HOST_RESET_N_OE_N === 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
    chk("self reset width", 16'(n), 16'h0014);
    cyc(4);
    REPLY_LOAD = 1'b1;
    cyc(1);
    REPLY_LOAD = 1'b0;
    cyc(2);
    rst_rel = 1'b0;
    cyc(6);
    chk("core reset", CORE_RESET_N, 16'h0000);
    chk("pending reset", REPLY_PENDING_N, 16'h0001);
    rst_rel = 1'b1;
    cyc(6);
    chk("core release", CORE_RESET_N, 16'h0001);
    results();
  end
endmodule : pchp_top_tb_top
